/* hdl/dram_row_strobe_bank_select.sv */
// Purpose: Chooses which of four active-low row strobes follow the internal row strobe,
//          recognises accesses to the memory region, returns ready and shapes the column
//          strobe for fast-page or extended-data-out parts.
// Assumes: The state machine and the processor run on clock_in, so no input is synchronised.
// Notes: Refresh ignores the captured bank pair and the access state.
`timescale 1ns/10ps
module dram_row_strobe_bank_select (
   input wire logic clock_in,
   input wire logic nrst_in,
   input wire logic [ras_bank_pkg::CFG_W-1:0] cfg_word_in,
   input wire ras_bank_pkg::proc_bus_s bus_in,
   input wire ras_bank_pkg::sm_ctrl_s sm_in,
   output logic [ras_bank_pkg::NUM_RAS-1:0] ras_n_out,
   output logic cas_n_out,
   output logic mux_sel_a_out,
   output logic mux_sel_b_out,
   output logic dram_access_out,
   output logic ready_out
);
   import ras_bank_pkg::*;

   // Configuration fields pulled out of the configuration word.
   wire logic dual_bank_module_sel = cfg_word_in[CFG_DUAL_BIT];
   wire logic [1:0] depth_code = cfg_word_in[CFG_DEPTH_HI:CFG_DEPTH_LO];
   wire logic edo_sel = cfg_word_in[CFG_EDO_BIT];

   // Registered state of the block.
   logic [NUM_RAS-1:0] ras_n_q; // Row strobe outputs, active low.
   logic [NUM_RAS-1:0] ras_n_d;
   logic cas_n_q; // Column strobe output, active low.
   logic cas_n_d;
   logic mux_sel_a_q; // First copy of the registered row strobe.
   logic mux_sel_b_q; // Second, identical copy.
   logic active_q; // An access to the memory region is in progress.
   logic active_d;
   logic ready_q; // Ready acknowledgment to the processor.
   logic write_q; // Direction of the current access.
   logic [1:0] bank_pair_q; // Bank-select address pair captured in the address cycle.

   // Region decode: the top two address bits serve only this purpose.
   wire logic region_hit = (bus_in.addr[REGION_HI:REGION_LO] == REGION_DRAM);
   wire logic access_go = !bus_in.ads_n && region_hit;

   // Depth multiplexer; bits 29:26 and pairs above the depth never reach the decode.
   wire logic [1:0] pair_256k = bus_in.addr[PAIR_256K_LO +: 2];
   wire logic [1:0] pair_1m = bus_in.addr[PAIR_1M_LO +: 2];
   wire logic [1:0] pair_4m = bus_in.addr[PAIR_4M_LO +: 2];
   wire logic [1:0] sel_pair = (depth_code == DEPTH_256K) ? pair_256k :
                               (depth_code == DEPTH_1M) ? pair_1m : pair_4m;

   // Single-bank decode: the lower bit picks strobe 0 or 1, the upper bit picks none.
   wire logic [3:0] single_sel = bank_pair_q[1] ? RAS_NONE :
                                 (bank_pair_q[0] ? 4'h2 : 4'h1);

   // Dual-bank decode: swapping the pair bits orders banks as 0, 2, 1, 3 so that one
   // dual-bank module alone forms contiguous memory.
   wire logic [1:0] dual_idx = {bank_pair_q[0], bank_pair_q[1]};
   wire logic [3:0] dual_sel = 4'h1 << dual_idx;

   // Refresh pattern covers only the strobes the bank setting enables.
   wire logic [3:0] refresh_sel = dual_bank_module_sel ? RAS_REFRESH_DUAL :
                                  RAS_REFRESH_SINGLE;
   wire logic [3:0] access_sel = dual_bank_module_sel ? dual_sel : single_sel;
   wire logic [3:0] bank_sel = sm_in.refresh ? refresh_sel : access_sel;

   // Outputs are forced high unless the internal row strobe is active.
   always_comb begin
      ras_n_d = ~(sm_in.ras ? bank_sel : RAS_NONE);
   end

   // Fast-page parts float data when the column strobe rises, so a read keeps it low
   // until the processor has taken the data; extended-data-out parts keep driving, so
   // the strobe may follow the state machine and rise early for the next location.
   wire logic fpm_read_hold = !edo_sel && active_q && !write_q && sm_in.read_hold;
   always_comb begin
      cas_n_d = !(sm_in.cas || fpm_read_hold);
   end

   // The access stays open until the last ready; a new address cycle reopens it.
   always_comb begin
      active_d = active_q;
      if (access_go) begin
         active_d = 1'b1;
      end else if (active_q && sm_in.ready_req && sm_in.last) begin
         active_d = 1'b0;
      end
   end

   // Row and column strobe registers.
   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         ras_n_q <= RAS_N_IDLE;
         cas_n_q <= 1'b1;
      end else begin
         ras_n_q <= ras_n_d;
         cas_n_q <= cas_n_d;
      end
   end

   // Two flip-flops share the multiplexer select load instead of one flip-flop with
   // buffers, which would add delay.
   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         mux_sel_a_q <= 1'b0;
         mux_sel_b_q <= 1'b0;
      end else begin
         mux_sel_a_q <= sm_in.ras;
         mux_sel_b_q <= sm_in.ras;
      end
   end

   // Access tracking, address capture and ready.
   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         active_q <= 1'b0;
         write_q <= 1'b0;
         bank_pair_q <= 2'h0;
         ready_q <= 1'b0;
      end else begin
         active_q <= active_d;
         if (access_go) begin
            write_q <= bus_in.write;
            bank_pair_q <= sel_pair;
         end
         // Ready ignores whether any bank was selected.
         ready_q <= active_q && sm_in.ready_req;
      end
   end

   assign ras_n_out = ras_n_q;
   assign cas_n_out = cas_n_q;
   assign mux_sel_a_out = mux_sel_a_q;
   assign mux_sel_b_out = mux_sel_b_q;
   assign dram_access_out = active_q;
   assign ready_out = ready_q;

   // Single-bank mode keeps the upper strobes high in every cycle.
   a_single_upper_idle: assert property (
      @(posedge clock_in) disable iff (!nrst_in)
      !dual_bank_module_sel |=> ras_n_out[3:2] == 2'h3)
      else $error("upper strobe driven in single-bank mode");

   // A dual-bank refresh drives every strobe at once.
   a_refresh_all_low: assert property (
      @(posedge clock_in) disable iff (!nrst_in)
      (sm_in.ras && sm_in.refresh && dual_bank_module_sel) |=> ras_n_out == RAS_NONE)
      else $error("refresh did not drive all strobes");

   // A dual-bank access drives exactly one strobe, placed by the swapped pair.
   a_dual_one_bank: assert property (
      @(posedge clock_in) disable iff (!nrst_in)
      (sm_in.ras && !sm_in.refresh && dual_bank_module_sel)
      |=> $onehot(~ras_n_out) && !ras_n_out[$past({bank_pair_q[0], bank_pair_q[1]})])
      else $error("dual-bank access strobe wrong");

   // A single-bank access to a populated bank drives exactly one of the lower strobes.
   a_single_one_bank: assert property (
      @(posedge clock_in) disable iff (!nrst_in)
      (sm_in.ras && !sm_in.refresh && !dual_bank_module_sel && !bank_pair_q[1])
      |=> $onehot(~ras_n_out) && !ras_n_out[$past(bank_pair_q[0])])
      else $error("single-bank access strobe wrong");

   // No internal strobe means every row strobe output is high.
   a_idle_all_high: assert property (
      @(posedge clock_in) disable iff (!nrst_in)
      !sm_in.ras |=> ras_n_out == RAS_N_IDLE)
      else $error("strobe driven while internal strobe idle");

   // Upper pair bit set in single-bank mode selects nothing.
   a_single_upper_none: assert property (
      @(posedge clock_in) disable iff (!nrst_in)
      (sm_in.ras && !sm_in.refresh && !dual_bank_module_sel && bank_pair_q[1])
      |=> ras_n_out == RAS_N_IDLE)
      else $error("strobe driven for unpopulated bank");

   // Smallest depth captures address bits 21:20.
   a_depth_pair_pick: assert property (
      @(posedge clock_in) disable iff (!nrst_in)
      (access_go && depth_code == DEPTH_256K) |=> bank_pair_q == $past(bus_in.addr[21:20]))
      else $error("wrong bank-select pair captured");

   // Both select copies follow the internal strobe one cycle late.
   a_copies_match: assert property (
      @(posedge clock_in) disable iff (!nrst_in)
      ##1 (mux_sel_a_out == $past(sm_in.ras)) && (mux_sel_b_out == mux_sel_a_out))
      else $error("select copies disagree");

   // An address outside the region never opens an access.
   a_region_gate: assert property (
      @(posedge clock_in) disable iff (!nrst_in)
      (!active_q && (bus_in.ads_n || !region_hit)) |=> !dram_access_out)
      else $error("access opened outside the region");

   // Ready follows every request inside an open access.
   a_ready_region: assert property (
      @(posedge clock_in) disable iff (!nrst_in)
      (active_q && sm_in.ready_req) |=> ready_out)
      else $error("ready missing for region access");

   // Fast-page reads keep the column strobe low while the processor takes data.
   a_fpm_cas_hold: assert property (
      @(posedge clock_in) disable iff (!nrst_in)
      (!edo_sel && active_q && !write_q && sm_in.read_hold) |=> !cas_n_out)
      else $error("column strobe released during fast-page read");

   // Extended-data-out parts release the column strobe with the state machine.
   a_edo_cas_release: assert property (
      @(posedge clock_in) disable iff (!nrst_in)
      (edo_sel && !sm_in.cas) |=> cas_n_out)
      else $error("column strobe held on extended-data-out part");
endmodule : dram_row_strobe_bank_select

/* hdl/ras_bank_pkg.sv */
// Purpose: Shared constants and carrier types for the row-strobe bank selection block.
// Assumes: One processor clock; the processor, the state machine and the memory modules
//          all run on it.
// Notes: The configuration word layout is fixed here so that bench and design agree on it.
package ras_bank_pkg;
   // Configuration word width and field positions.
   localparam int CFG_W = 16;
   localparam int CFG_DUAL_BIT = 14;
   localparam int CFG_DEPTH_HI = 13;
   localparam int CFG_DEPTH_LO = 12;
   localparam int CFG_EDO_BIT = 15;
   // Address positions used by the region decode and the depth multiplexer.
   localparam int ADDR_W = 32;
   localparam int REGION_HI = 31;
   localparam int REGION_LO = 30;
   localparam logic [1:0] REGION_DRAM = 2'h0;
   localparam int PAIR_256K_LO = 20;
   localparam int PAIR_1M_LO = 22;
   localparam int PAIR_4M_LO = 24;
   // Depth codes; the upper bit alone selects the largest depth.
   localparam logic [1:0] DEPTH_256K = 2'h0;
   localparam logic [1:0] DEPTH_1M = 2'h1;
   // Strobe patterns, one bit per bank, active high before inversion; RAS_N_IDLE is already active low.
   localparam int NUM_RAS = 4;
   localparam logic [3:0] RAS_NONE = 4'h0;
   localparam logic [3:0] RAS_REFRESH_SINGLE = 4'h3;
   localparam logic [3:0] RAS_REFRESH_DUAL = 4'hF;
   localparam logic [3:0] RAS_N_IDLE = 4'hF;

   // Processor bus signals sampled in the address cycle and after.
   typedef struct packed {
      logic ads_n;
      logic write;
      logic [ADDR_W-1:0] addr;
   } proc_bus_s;

   // Control signals coming from the controller state machine.
   typedef struct packed {
      logic ras;
      logic cas;
      logic refresh;
      logic read_hold;
      logic ready_req;
      logic last;
   } sm_ctrl_s;
endpackage : ras_bank_pkg

/* verification/simm_sockets_model.sv */
// Purpose: Two memory sockets that note which banks see their row strobe low.
// Assumes: Strobes are active low and sampled on the processor clock.
// Notes: Data pins are not modelled, because the block drives no data of its own.
`timescale 1ns/10ps
module simm_sockets_model (
   input wire logic clock_in,
   input wire logic [3:0] ras_n_in,
   input wire logic cas_n_in,
   output logic [3:0] bank_open_out,
   output logic col_open_out
);
   // A bank counts as open while its strobe stays low; the column strobe is noted too.
   always_ff @(posedge clock_in) begin
      bank_open_out <= ~ras_n_in;
      col_open_out <= ~cas_n_in;
   end
endmodule : simm_sockets_model

/* verification/dram_row_strobe_bank_select_tb.sv */
// Purpose: Self-checking bench for the row-strobe bank selection block.
// Assumes: Inputs change at the falling edge; outputs are read at the falling edge.
// Notes: The driver queues one note per strobe cycle; the monitor checks it.
`timescale 1ns/10ps
module dram_row_strobe_bank_select_tb;
   import ras_bank_pkg::*;
   // Expected outputs of one strobe cycle.
   typedef struct packed {
      logic [3:0] ras_n;
      logic ready;
      logic cas_n;
      logic access;
   } note_s;
   logic clock_in = 1'b0;
   logic nrst_in = 1'b0;
   logic [CFG_W-1:0] cfg_word_in = '0;
   proc_bus_s bus_in = '{ads_n: 1'b1, write: 1'b0, addr: '0};
   sm_ctrl_s sm_in = '0;
   logic [3:0] ras_n_out;
   logic [3:0] bank_open;
   logic cas_n_out, mux_sel_a_out, mux_sel_b_out, dram_access_out, ready_out;
   logic col_open;
   logic [3:0] open_exp = 4'h0;
   logic col_exp = 1'b0;
   logic open_due = 1'b0;
   logic access_seen = 1'b0;
   int num_errors = 0;
   int checks_done = 0;
   note_s notes[$];
   note_s n;

   // The clock inverts every half period of 4 ns.
   always #4 clock_in = ~clock_in;

   dram_row_strobe_bank_select i_dut (.clock_in(clock_in), .nrst_in(nrst_in),
      .cfg_word_in(cfg_word_in), .bus_in(bus_in), .sm_in(sm_in), .ras_n_out(ras_n_out),
      .cas_n_out(cas_n_out), .mux_sel_a_out(mux_sel_a_out), .mux_sel_b_out(mux_sel_b_out),
      .dram_access_out(dram_access_out), .ready_out(ready_out));
   simm_sockets_model i_mem (.clock_in(clock_in), .ras_n_in(ras_n_out),
      .cas_n_in(cas_n_out), .bank_open_out(bank_open), .col_open_out(col_open));

   // Banks selected, active high; worked out independently of the design.
   function automatic logic [3:0] exp_sel(input logic [CFG_W-1:0] cfg, input logic [31:0] a,
                                          input logic refr);
      logic [1:0] p;
      p = cfg[13] ? a[25:24] : (cfg[12] ? a[23:22] : a[21:20]);
      if (refr) return cfg[14] ? RAS_REFRESH_DUAL : RAS_REFRESH_SINGLE;
      if (cfg[14]) return 4'h1 << {p[0], p[1]};
      return p[1] ? 4'h0 : (p[0] ? 4'h2 : 4'h1);
   endfunction : exp_sel

   task automatic compare_vec(input string what, input logic [3:0] exp, input logic [3:0] got);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : compare_vec

   task automatic compare_bit(input string what, input logic exp, input logic got);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
      end
   endtask : compare_bit

   // One address cycle, then one strobe cycle that also asks for a final ready.
   task automatic strobe_cycle(input logic [CFG_W-1:0] cfg, input logic [31:0] a,
                               input logic refr, input logic wr);
      logic hit;
      hit = (a[31:30] == REGION_DRAM);
      @(negedge clock_in);
      cfg_word_in = cfg;
      bus_in = '{ads_n: 1'b0, write: wr, addr: a};
      @(negedge clock_in);
      bus_in.ads_n = 1'b1;
      sm_in = '{ras: 1'b1, cas: 1'b0, refresh: refr, read_hold: 1'b1, ready_req: 1'b1,
                last: 1'b1};
      notes.push_back('{~exp_sel(cfg, a, refr), hit, ~(hit & ~cfg[15] & ~wr), hit});
      @(negedge clock_in);
      sm_in = '0;
   endtask : strobe_cycle

   // Monitor: each strobe cycle shows up one clock later on both select copies. The
   // access flag stood one cycle before that, and the sockets see it one cycle after.
   always @(negedge clock_in) begin
      if (open_due) begin
         compare_vec("bank_open", open_exp, bank_open);
         compare_bit("col_open", col_exp, col_open);
      end
      open_due = 1'b0;
      if (mux_sel_a_out === 1'b1) begin
         n = notes.pop_front();
         compare_vec("ras_n_out", n.ras_n, ras_n_out);
         compare_bit("ready_out", n.ready, ready_out);
         compare_bit("cas_n_out", n.cas_n, cas_n_out);
         compare_bit("mux_sel_b_out", 1'b1, mux_sel_b_out);
         compare_bit("dram_access_out", n.access, access_seen);
         open_exp = ~n.ras_n;
         col_exp = ~n.cas_n;
         open_due = 1'b1;
      end
      access_seen = dram_access_out;
   end

   task automatic print_verdict();
      $display("Checks done %0d, errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : print_verdict

   // Watchdog: the tests need well under 4000 cycles.
   initial begin
      #(8 * 4000);
      num_errors++;
      print_verdict();
   end

   // Main sequence: every edo, bank and depth setting, each pair value, then a refresh.
   initial begin
      int seed;
      logic [31:0] a;
      logic [CFG_W-1:0] cfg;
      seed = $urandom(85331);
      repeat (6) @(posedge clock_in);
      @(negedge clock_in);
      compare_vec("reset ras_n_out", RAS_N_IDLE, ras_n_out);
      compare_bit("reset ready_out", 1'b0, ready_out);
      nrst_in = 1'b1;
      for (int c = 0; c < 16; c++) begin
         cfg = {c[3:0], 12'($urandom())};
         for (int k = 0; k < 8; k++) begin
            a = $urandom();
            a[31:30] = REGION_DRAM;
            if (c[1]) a[25:24] = k[1:0];
            else if (c[0]) a[23:22] = k[1:0];
            else a[21:20] = k[1:0];
            strobe_cycle(cfg, a, 1'b0, k[2]);
         end
         // A refresh aimed outside the region must give strobes but no ready.
         a = $urandom();
         a[31:30] = 2'(c % 3 + 1);
         strobe_cycle(cfg, a, 1'b1, 1'b0);
      end
      repeat (3) @(negedge clock_in);
      compare_vec("notes left", 4'h0, 4'(notes.size()));
      print_verdict();
   end
endmodule : dram_row_strobe_bank_select_tb
